// file: asc_pkg.sv
// register map, field layouts, counts and types of the serial control block
// Behaviour
// - loop mode feeds transmitter output to receiver; needs tx_on and rx_on
// - serial_enable_bit runs block and baud; clear forces tx flags high, tx irqs off
// - tx_invert flips every level on tx_pin, idle and break too
// - char_length_select picks 10-bit or 11-bit frames
// - parity_on puts parity in top payload bit
// - parity_odd_select picks odd or even, for send and check
// - wake method: address mark or idle line ends standby
// - idle_count_origin starts ones count after start bit or after stop bit
// - tx empty goes to interrupt, or to dma request when dma enabled
// - rx full goes to interrupt, or to dma request when dma enabled
// - tx_done_irq_en and idle_irq_en gate their flags onto interrupt
// - setting tx_on sends a preamble of 10 or 11 ones
// - clearing tx_on lets the current frame finish, then line idles high
// - clearing rx_on stops receiver, flags stay as they are
// - rx_standby mutes receiver interrupts until wake condition clears it
// - break_send set then cleared sends one break then one logic one
// - break_send held sends breaks back to back without gaps
// - rx_ninth_bit captured with received byte in 9-bit frames
// - tx_ninth_bit loaded into shifter with data byte as bit 8 in 9-bit frames with parity_on clear
// - four error enables gate overrun, noise, framing, parity flags
// - reset clears control bits, ninth bits keep their values
// - tx_empty sets on shifter load; tx_done sets when empty and idle
package asc_pkg;
	// ----------------------------------------
	// register indices
	// ----------------------------------------
	localparam logic [2:0] ADDR_FORMAT = 3'h0;
	localparam logic [2:0] ADDR_CTRL = 3'h1;
	localparam logic [2:0] ADDR_ERRC = 3'h2;
	localparam logic [2:0] ADDR_STAT1 = 3'h3;
	localparam logic [2:0] ADDR_STAT2 = 3'h4;
	localparam logic [2:0] ADDR_DATA = 3'h5;
	// ----------------------------------------
	// fields, frame sizes, flag positions
	// ----------------------------------------
	localparam int ERR_TX8_BIT = 6;
	localparam int CTL_TXON_BIT = 3;
	localparam logic [3:0] FRAME_LEN_8 = 4'hA;
	localparam logic [3:0] FRAME_LEN_9 = 4'hB;
	localparam int CLK_HZ = 100000000;
	localparam int BAUD_RATE = 9600;
	localparam int BAUD_DIV_DEF = CLK_HZ / BAUD_RATE;
	typedef struct packed {
		logic loop_select;
		logic serial_enable_bit;
		logic tx_invert;
		logic char_length_select;
		logic wake_select;
		logic idle_count_origin;
		logic parity_on;
		logic parity_odd_select;
	} asc_fmt_s;
	typedef struct packed {
		logic tx_empty_irq_en;
		logic tx_done_irq_en;
		logic rx_full_irq_en;
		logic idle_irq_en;
		logic tx_on;
		logic rx_on;
		logic rx_standby;
		logic break_send;
	} asc_ctl_s;
	typedef struct packed {
		logic rx_dma_req_en;
		logic tx_dma_req_en;
		logic overrun_irq_en;
		logic noise_irq_en;
		logic framing_irq_en;
		logic parity_err_irq_en;
	} asc_err_s;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} asc_bus_s;
	localparam asc_fmt_s RST_FMT = '0;
	localparam asc_ctl_s RST_CTL = '0;
	localparam asc_err_s RST_ERR = '0;
	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} asc_tx_e;
	typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RUN = 2'b10} asc_rx_e;
endpackage : asc_pkg

// file: asc_serial_ctrl.sv
// serial interface control registers with transmitter and receiver
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module asc_serial_ctrl
	import asc_pkg::*;
#(
	parameter int BAUD_DIV = BAUD_DIV_DEF // clock cycles per bit
) (
	input wire logic clock, // system clock
	input wire logic nrst, // async reset
	input wire asc_bus_s bus, // register request
	output logic [7:0] rdata, // read data
	input wire logic rx_pin, // serial input
	output logic tx_pin, // serial output
	output logic cpu_irq, // interrupt request
	output logic tx_dma_req, // tx dma request
	output logic rx_dma_req // rx dma request
);

	// ----------------------------------------
	// registers and decode
	// ----------------------------------------
	asc_fmt_s c1_ff;
	asc_ctl_s c2_ff;
	asc_err_s c3_ff;
	logic rx_ninth_ff;
	logic tx_ninth_ff;
	logic [7:0] tx_buf_ff;
	logic [7:0] rx_buf_ff;
	logic tx_empty_ff;
	logic tx_done_ff;
	logic [6:0] rxf_ff;
	logic arm_ff;
	logic wake_hit;
	logic rx_take;
	logic [7:0] rx_d;
	logic rx_b8;

	// strobes per register
	wire en = c1_ff.serial_enable_bit;
	wire cls = c1_ff.char_length_select;
	wire wr_fmt = bus.wr && (bus.addr == ADDR_FORMAT);
	wire wr_ctl = bus.wr && (bus.addr == ADDR_CTRL);
	wire wr_err = bus.wr && (bus.addr == ADDR_ERRC);
	wire wr_data = bus.wr && (bus.addr == ADDR_DATA);
	wire rd_data = bus.rd && (bus.addr == ADDR_DATA);
	wire rd_st1 = bus.rd && (bus.addr == ADDR_STAT1);
	wire rd_st2 = bus.rd && (bus.addr == ADDR_STAT2);
	// dma owns the flag when both enables are set
	wire tx_dma_on = c2_ff.tx_empty_irq_en && c3_ff.tx_dma_req_en;
	wire rx_dma_on = c2_ff.rx_full_irq_en && c3_ff.rx_dma_req_en;
	wire tx_clr = wr_data && (arm_ff || tx_dma_on);
	wire rx_clr = rd_data && (arm_ff || rx_dma_on);
	wire [3:0] frame_len = cls ? FRAME_LEN_9 : FRAME_LEN_8;

	// control registers, standby cleared by wake
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			c1_ff <= RST_FMT;
			c2_ff <= RST_CTL;
			c3_ff <= RST_ERR;
		end else begin
			if (wr_fmt)
				c1_ff <= asc_fmt_s'(bus.wdata);
			if (wr_ctl)
				c2_ff <= asc_ctl_s'(bus.wdata);
			else if (wake_hit)
				c2_ff.rx_standby <= 1'b0;
			if (wr_err)
				c3_ff <= asc_err_s'(bus.wdata[5:0]);
		end
	end

	// data and ninth bits, untouched by reset
	always_ff @(posedge clock) begin
		if (wr_err)
			tx_ninth_ff <= bus.wdata[ERR_TX8_BIT];
		if (wr_data)
			tx_buf_ff <= bus.wdata;
		if (rx_take) begin
			rx_buf_ff <= rx_d;
			rx_ninth_ff <= rx_b8;
		end
	end

	// status read arms the flag clear on data access
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			arm_ff <= 1'b0;
		else if (rd_st1 || rd_st2)
			arm_ff <= 1'b1;
		else if (rd_data || wr_data)
			arm_ff <= 1'b0;
	end

	// ----------------------------------------
	// baud divider
	// ----------------------------------------
	logic [15:0] bd_cnt_ff;
	wire bd_tick = en && (bd_cnt_ff == 16'(BAUD_DIV - 1));

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			bd_cnt_ff <= '0;
		else if (!en || bd_tick)
			bd_cnt_ff <= '0;
		else
			bd_cnt_ff <= bd_cnt_ff + 16'h0001;
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	asc_tx_e tx_state_ff;
	asc_tx_e nxt_tx_state;
	logic [10:0] tx_sh_ff;
	logic [3:0] tx_cnt_ff;
	logic pre_pend_ff;
	logic brk_run_ff;

	// frame assembly with parity in the top payload bit
	wire tx_last = (tx_state_ff == TX_SEND) && bd_tick && (tx_cnt_ff == 4'h1);
	wire tx_free = (tx_state_ff == TX_IDLE) || tx_last;
	wire [8:0] tx_pay = cls ? {1'b0, tx_buf_ff} : {2'b00, tx_buf_ff[6:0]};
	wire tx_par = (^tx_pay) ^ c1_ff.parity_odd_select;
	wire [7:0] tx_d = (c1_ff.parity_on && !cls) ? {tx_par, tx_buf_ff[6:0]} : tx_buf_ff;
	wire tx_b8 = c1_ff.parity_on ? tx_par : tx_ninth_ff;
	wire [10:0] tx_frame = cls ? {1'b1, tx_b8, tx_d, 1'b0} : {2'b11, tx_d, 1'b0};

	// what starts next: preamble, break, mark after break, data
	wire go_pre = tx_free && en && c2_ff.tx_on && pre_pend_ff;
	wire go_brk = tx_free && en && c2_ff.tx_on && c2_ff.break_send && !go_pre;
	wire go_mark = tx_free && en && brk_run_ff && !c2_ff.break_send && !go_pre;
	wire go_dat = tx_free && en && c2_ff.tx_on && !tx_empty_ff && !go_pre && !go_brk
		&& !go_mark;
	wire go_any = go_pre || go_brk || go_mark || go_dat;
	wire [10:0] tx_load = (go_pre || go_mark) ? 11'h7FF : (go_brk ? 11'h000 : tx_frame);
	wire [3:0] tx_load_cnt = go_mark ? 4'h1 : frame_len;
	wire tx_line = (tx_state_ff == TX_SEND) ? tx_sh_ff[0] : 1'b1;

	// transmit state
	always_comb begin
		case (tx_state_ff)
			TX_IDLE: nxt_tx_state = go_any ? TX_SEND : TX_IDLE;
			TX_SEND: nxt_tx_state = (go_any || !tx_last) ? TX_SEND : TX_IDLE;
			default: nxt_tx_state = TX_IDLE;
		endcase
		if (!en)
			nxt_tx_state = TX_IDLE;
	end

	// shifter, lsb first on each baud tick
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_state_ff <= TX_IDLE;
			tx_sh_ff <= 11'h7FF;
			tx_cnt_ff <= 4'h0;
		end else begin
			tx_state_ff <= nxt_tx_state;
			if (go_any) begin
				tx_sh_ff <= tx_load;
				tx_cnt_ff <= tx_load_cnt;
			end else if (bd_tick) begin
				tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
				tx_cnt_ff <= tx_cnt_ff - 4'h1;
			end
		end
	end

	// preamble request on tx_on rising, break memory
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pre_pend_ff <= 1'b0;
			brk_run_ff <= 1'b0;
		end else begin
			if (wr_ctl && bus.wdata[CTL_TXON_BIT] && !c2_ff.tx_on)
				pre_pend_ff <= 1'b1;
			else if (go_pre)
				pre_pend_ff <= 1'b0;
			if (!en)
				brk_run_ff <= 1'b0;
			else if (go_any || tx_free)
				brk_run_ff <= go_brk;
		end
	end

	// empty and done flags
	wire done_set = tx_empty_ff && (tx_state_ff == TX_IDLE) && !go_any && !wr_data;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_empty_ff <= 1'b1;
			tx_done_ff <= 1'b1;
		end else if (!en) begin
			tx_empty_ff <= 1'b1;
			tx_done_ff <= 1'b1;
		end else begin
			if (go_dat)
				tx_empty_ff <= 1'b1;
			else if (tx_clr)
				tx_empty_ff <= 1'b0;
			if (done_set)
				tx_done_ff <= 1'b1;
			else if (tx_clr || go_any)
				tx_done_ff <= 1'b0;
		end
	end

	// registered pin, inversion covers every level
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			tx_pin <= 1'b1;
		else
			tx_pin <= tx_line ^ c1_ff.tx_invert;
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	asc_rx_e rx_state_ff;
	asc_rx_e nxt_rx_state;
	logic [2:0] rx_hist_ff;
	logic [15:0] rx_cnt_ff;
	logic [3:0] rx_bit_ff;
	logic [10:0] rx_sh_ff;
	logic rx_nz_ff;
	logic [3:0] ones_ff;
	logic idle_arm_ff;

	// input select, three-sample vote
	wire rx_in = c1_ff.loop_select ? tx_line : rx_pin;
	wire rx_maj = (rx_hist_ff[0] & rx_hist_ff[1]) | (rx_hist_ff[0] & rx_hist_ff[2])
		| (rx_hist_ff[1] & rx_hist_ff[2]);
	wire rx_noisy = (|rx_hist_ff) && !(&rx_hist_ff);
	wire rx_active = en && c2_ff.rx_on;
	wire rx_run = rx_state_ff == RX_RUN;
	wire rx_samp = rx_cnt_ff == 16'h0000;
	wire rx_go = (rx_state_ff == RX_IDLE) && rx_active && rx_hist_ff[1] && !rx_hist_ff[0];
	wire rx_false = rx_run && rx_samp && (rx_bit_ff == 4'h0) && rx_maj;
	wire rx_done = rx_run && rx_samp && (rx_bit_ff == frame_len - 4'h1);

	// frame fields once the stop bit is sampled
	wire [10:0] rx_fr = {rx_maj, rx_sh_ff[10:1]};
	assign rx_d = cls ? rx_fr[8:1] : rx_fr[9:2];
	assign rx_b8 = rx_fr[9];
	wire [8:0] rx_pay = cls ? {rx_b8, rx_d} : {1'b0, rx_d};
	wire rx_perr = c1_ff.parity_on && ((^rx_pay) != c1_ff.parity_odd_select);
	wire rx_brk = (rx_pay == 9'h000) && !rx_maj;
	wire rx_msb = cls ? rx_b8 : rx_d[7];
	assign rx_take = rx_done && !rxf_ff[6];

	// idle detection and wake
	wire ones_top = ones_ff == frame_len;
	wire idle_hit = rx_active && !rx_run && rx_samp && rx_maj && (ones_ff == frame_len - 4'h1);
	assign wake_hit = c2_ff.rx_standby
		&& (c1_ff.wake_select ? (rx_done && rx_msb) : idle_hit);

	// receive state
	always_comb begin
		case (rx_state_ff)
			RX_IDLE: nxt_rx_state = rx_go ? RX_RUN : RX_IDLE;
			RX_RUN: nxt_rx_state = (rx_done || rx_false) ? RX_IDLE : RX_RUN;
			default: nxt_rx_state = RX_IDLE;
		endcase
		if (!rx_active)
			nxt_rx_state = RX_IDLE;
	end

	// bit timer and shifter
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_state_ff <= RX_IDLE;
			rx_hist_ff <= 3'h7;
			rx_cnt_ff <= '0;
			rx_bit_ff <= 4'h0;
			rx_sh_ff <= '0;
			rx_nz_ff <= 1'b0;
		end else begin
			rx_state_ff <= nxt_rx_state;
			rx_hist_ff <= {rx_hist_ff[1:0], rx_in};
			if (rx_go) begin
				rx_cnt_ff <= 16'(BAUD_DIV / 2);
				rx_bit_ff <= 4'h0;
				rx_nz_ff <= 1'b0;
			end else if (rx_samp) begin
				rx_cnt_ff <= 16'(BAUD_DIV - 1);
				if (rx_run) begin
					rx_sh_ff <= rx_fr;
					rx_bit_ff <= rx_bit_ff + 4'h1;
					rx_nz_ff <= rx_nz_ff | rx_noisy;
				end
			end else begin
				rx_cnt_ff <= rx_cnt_ff - 16'h0001;
			end
		end
	end

	// consecutive ones, origin after start or after stop
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			ones_ff <= 4'h0;
		else if (!rx_active)
			ones_ff <= 4'h0;
		else if (rx_samp) begin
			if (!rx_run || !c1_ff.idle_count_origin)
				ones_ff <= !rx_maj ? 4'h0 : (ones_top ? ones_ff : ones_ff + 4'h1);
			else
				ones_ff <= 4'h0;
		end
	end

	// flags: full, idle, overrun, noise, framing, parity, break
	wire [6:0] rxf_set = {rx_take, idle_hit && idle_arm_ff, rx_done && rxf_ff[6],
		rx_take && (rx_nz_ff || rx_noisy), rx_take && !rx_maj, rx_take && rx_perr,
		rx_take && rx_brk};

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rxf_ff <= 7'h00;
			idle_arm_ff <= 1'b1;
		end else begin
			rxf_ff <= rxf_set | (rxf_ff & ~{7{rx_clr}});
			if (rx_take)
				idle_arm_ff <= 1'b1;
			else if (idle_hit)
				idle_arm_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// requests and read data
	// ----------------------------------------
	wire rx_ok = !c2_ff.rx_standby;
	wire tx_irq = en && ((tx_empty_ff && c2_ff.tx_empty_irq_en && !c3_ff.tx_dma_req_en)
		|| (tx_done_ff && c2_ff.tx_done_irq_en));
	wire rx_irq = rx_ok && ((rxf_ff[6] && c2_ff.rx_full_irq_en && !c3_ff.rx_dma_req_en)
		|| (rxf_ff[5] && c2_ff.idle_irq_en));
	wire err_irq = rx_ok && (|(rxf_ff[4:1] & {c3_ff.overrun_irq_en, c3_ff.noise_irq_en,
		c3_ff.framing_irq_en, c3_ff.parity_err_irq_en}));
	wire [7:0] rd_mux = (bus.addr == ADDR_FORMAT) ? c1_ff
		: (bus.addr == ADDR_CTRL) ? c2_ff
		: (bus.addr == ADDR_ERRC) ? {rx_ninth_ff, tx_ninth_ff, c3_ff}
		: (bus.addr == ADDR_STAT1) ? {tx_empty_ff, tx_done_ff, rxf_ff[6:1]}
		: (bus.addr == ADDR_STAT2) ? {6'h00, rxf_ff[0], rx_run}
		: (bus.addr == ADDR_DATA) ? rx_buf_ff : 8'h00;

	// registered outputs
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cpu_irq <= 1'b0;
			tx_dma_req <= 1'b0;
			rx_dma_req <= 1'b0;
			rdata <= 8'h00;
		end else begin
			cpu_irq <= tx_irq || rx_irq || err_irq;
			tx_dma_req <= en && tx_empty_ff && tx_dma_on;
			rx_dma_req <= rx_ok && rxf_ff[6] && rx_dma_on;
			rdata <= bus.rd ? rd_mux : 8'h00;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	a_loop_route: assert property (c1_ff.loop_select |-> rx_in == tx_line)
		else $error("loop input not the transmitter");
	a_disable_flags: assert property (!en |=> tx_empty_ff && tx_done_ff && !tx_dma_req)
		else $error("disabled block left tx flags low");
	a_idle_level: assert property ($past(tx_state_ff == TX_IDLE) |-> tx_pin == !$past(c1_ff.tx_invert))
		else $error("idle pin level wrong");
	a_preamble_len: assert property (go_pre |=> tx_sh_ff == 11'h7FF && tx_cnt_ff == $past(frame_len))
		else $error("preamble length wrong");
	a_break_gapless: assert property (tx_last && brk_run_ff && c2_ff.break_send && c2_ff.tx_on
		&& !pre_pend_ff |=> tx_sh_ff == 11'h000 && tx_state_ff == TX_SEND)
		else $error("gap between break characters");
	a_ninth_load: assert property (go_dat && cls && !c1_ff.parity_on |=> tx_sh_ff[9] == tx_ninth_ff)
		else $error("ninth bit not loaded");
	a_rx_ninth: assert property (rx_take ##1 c3_ff == $past(c3_ff) |-> rx_ninth_ff == $past(rx_b8))
		else $error("received ninth bit not captured");
	a_standby_mute: assert property (c2_ff.rx_standby ##1 c2_ff.rx_standby |-> !rx_dma_req)
		else $error("dma request during standby");
	a_done_empty: assert property (tx_done_ff && en |-> tx_empty_ff)
		else $error("done without empty");
	a_dma_excl: assert property (##1 rx_dma_req |-> !$past(rx_irq && !c2_ff.idle_irq_en))
		else $error("rx full raised both irq and dma");

endmodule : asc_serial_ctrl

// file: asc_remote.sv
// far-end serial transceiver model for the control block bench
`timescale 1ns/1ps
module asc_remote #(
	parameter int BAUD_DIV = 16 // clock cycles per bit
) (
	input wire logic clock, // system clock
	input wire logic line_in, // device transmit line
	input wire logic [3:0] frame_len, // bits per frame incl start and stop
	output logic line_out // device receive line, idles high
);
	logic [8:0] got; // last payload caught
	logic got_stop; // stop level of last frame
	int n_got; // frames caught so far
	initial begin
		line_out = 1'b1;
		n_got = 0;
	end
	// catcher: falling edge, then mid-bit samples on the quiet clock edge
	always begin
		@(negedge line_in);
		repeat (BAUD_DIV / 2) @(negedge clock);
		if (line_in === 1'b0) begin
			got = '0;
			for (int i = 0; i < frame_len - 2; i++) begin
				repeat (BAUD_DIV) @(negedge clock);
				got[i] = line_in;
			end
			repeat (BAUD_DIV) @(negedge clock);
			got_stop = line_in;
			n_got++;
		end
	end
	// sender: start bit, payload lsb first, one stop bit
	task send(input logic [8:0] w, input int nb);
		@(posedge clock);
		line_out <= 1'b0;
		repeat (BAUD_DIV) @(posedge clock);
		for (int i = 0; i < nb; i++) begin
			line_out <= w[i];
			repeat (BAUD_DIV) @(posedge clock);
		end
		line_out <= 1'b1;
		repeat (BAUD_DIV) @(posedge clock);
	endtask : send
endmodule : asc_remote

// file: asc_serial_ctrl_bench.sv
// self-checking bench for the serial control registers
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module asc_serial_ctrl_bench
	import asc_pkg::*;
;
	localparam int BD = 16;
	logic clock, nrst, rx_pin, tx_pin, cpu_irq, tx_dma_req, rx_dma_req;
	asc_bus_s bus;
	logic [7:0] rdata, d;
	logic [3:0] flen;
	int err_count, n_checks, cnt, n0;
	logic [7:0] tf [5] = '{8'h42, 8'h42, 8'h43, 8'h52, 8'h50};
	logic [7:0] td [5] = '{8'h03, 8'h07, 8'h03, 8'h01, 8'h3C};
	logic [8:0] te [5] = '{9'h003, 9'h087, 9'h083, 9'h101, 9'h13C};

	asc_serial_ctrl #(.BAUD_DIV(BD)) uut (.clock(clock), .nrst(nrst), .bus(bus),
		.rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .cpu_irq(cpu_irq),
		.tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
	asc_remote #(.BAUD_DIV(BD)) remote (.clock(clock), .line_in(tx_pin),
		.frame_len(flen), .line_out(rx_pin));

	// ----------------------------------------
	// clock and bus tasks
	// ----------------------------------------
	always #5 clock = ~clock;
	task pass(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : pass
	task wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clock);
		bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(posedge clock);
		bus <= '0;
	endtask : wr
	task chk_rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clock);
		bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clock);
		bus <= '0;
		#1;
		`CHK(rdata & m, e)
	endtask : chk_rd
	// wait for the far end to catch a frame, then check it
	task wait_chk(input logic [8:0] e);
		cnt = 0;
		while (remote.n_got == n0 && cnt < 600) begin
			@(posedge clock);
			cnt++;
		end
		if (cnt >= 600)
			err_count++;
		`CHK(remote.got, e)
		`CHK(remote.got_stop, 1'b1)
		pass(BD);
	endtask : wait_chk
	task results;
		if (err_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		bus = '0;
		flen = FRAME_LEN_8;
		err_count = 0;
		n_checks = 0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		chk_rd(ADDR_FORMAT, 8'hFF, 8'h00);
		chk_rd(ADDR_CTRL, 8'hFF, 8'h00);
		chk_rd(ADDR_ERRC, 8'h3F, 8'h00);
		chk_rd(ADDR_STAT1, 8'hFF, 8'hC0);
		chk_rd(3'h7, 8'hFF, 8'h00);
		// ninth transmit bit survives a second reset
		wr(ADDR_ERRC, 8'h4F);
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		chk_rd(ADDR_ERRC, 8'h7F, 8'h40);
		// preamble then first 8-bit frame
		n0 = remote.n_got;
		wr(ADDR_FORMAT, 8'h40);
		wr(ADDR_CTRL, 8'h08);
		chk_rd(ADDR_STAT1, 8'h80, 8'h80);
		wr(ADDR_DATA, 8'hA5);
		cnt = 0;
		while (tx_pin !== 1'b0 && cnt < 400) begin
			@(negedge clock);
			cnt++;
		end
		`CHK(cnt >= 9 * BD - 4 && cnt <= 11 * BD, 1'b1)
		wait_chk(9'h0A5);
		chk_rd(ADDR_STAT1, 8'hC0, 8'hC0);
		// parity kinds, frame sizes and the ninth bit
		for (int i = 0; i < 5; i++) begin
			n0 = remote.n_got;
			flen = tf[i][4] ? FRAME_LEN_9 : FRAME_LEN_8;
			wr(ADDR_FORMAT, tf[i]);
			chk_rd(ADDR_STAT1, 8'h80, 8'h80);
			wr(ADDR_DATA, td[i]);
			wait_chk(te[i]);
		end
		// 9-bit reception, interrupt then dma routing
		wr(ADDR_CTRL, 8'h24);
		remote.send(9'h15A, 9);
		pass(BD);
		`CHK(cpu_irq, 1'b1)
		wr(ADDR_ERRC, 8'h20);
		pass(2);
		`CHK({rx_dma_req, cpu_irq}, 2'b10)
		wr(ADDR_CTRL, 8'h20);
		chk_rd(ADDR_STAT1, 8'h20, 8'h20);
		chk_rd(ADDR_DATA, 8'hFF, 8'h5A);
		chk_rd(ADDR_ERRC, 8'h80, 8'h80);
		// transmitter request routing and module disable
		wr(ADDR_FORMAT, 8'h40);
		wr(ADDR_ERRC, 8'h00);
		wr(ADDR_CTRL, 8'h80);
		pass(2);
		`CHK({tx_dma_req, cpu_irq}, 2'b01)
		wr(ADDR_ERRC, 8'h10);
		pass(2);
		`CHK({tx_dma_req, cpu_irq}, 2'b10)
		wr(ADDR_CTRL, 8'h40);
		pass(2);
		`CHK({tx_dma_req, cpu_irq}, 2'b01)
		wr(ADDR_FORMAT, 8'h00);
		pass(2);
		`CHK({tx_dma_req, cpu_irq}, 2'b00)
		// loop mode: own frame comes back as received data
		flen = FRAME_LEN_8;
		wr(ADDR_ERRC, 8'h00);
		wr(ADDR_FORMAT, 8'hC0);
		wr(ADDR_CTRL, 8'h0C);
		n0 = remote.n_got;
		chk_rd(ADDR_STAT1, 8'h80, 8'h80);
		wr(ADDR_DATA, 8'h96);
		wait_chk(9'h096);
		chk_rd(ADDR_STAT1, 8'h20, 8'h20);
		chk_rd(ADDR_DATA, 8'hFF, 8'h96);
		// held break has no high bits, release ends high, then inversion
		wr(ADDR_FORMAT, 8'h40);
		wr(ADDR_CTRL, 8'h09);
		pass(12 * BD);
		cnt = 0;
		repeat (25 * BD) begin
			@(negedge clock);
			cnt += (tx_pin !== 1'b0);
		end
		`CHK(cnt, 0)
		wr(ADDR_CTRL, 8'h08);
		pass(13 * BD);
		`CHK(tx_pin, 1'b1)
		wr(ADDR_FORMAT, 8'h60);
		pass(2);
		`CHK(tx_pin, 1'b0)
		results();
	end
	// watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		results();
	end
endmodule : asc_serial_ctrl_bench
